// ==== csd_map.svh ====
// Address map, field positions, reset values and sizes of the core status and data map
`ifndef CSD_MAP_SVH
`define CSD_MAP_SVH

// ==========================================================================
// Data space regions
`define CSD_IO_BASE 16'h0000
`define CSD_IO_LAST 16'h003f
`define CSD_SRAM_BASE 16'h0040
`define CSD_SRAM_BYTES 32
`define CSD_TOP_OF_SRAM 16'h005f
`define CSD_DIRECT_BASE 16'h0040
`define CSD_DIRECT_LAST 16'h00bf
`define CSD_LOCK_ADDR 16'h3f00
`define CSD_FLASH_BASE 16'h4000
`define CSD_FLASH_LAST 16'h43ff
`define CSD_FLASH_WORDS 512
`define CSD_PC_WIDTH 9
`define CSD_PC_RESET 9'h000

// ==========================================================================
// Core register offsets inside the I/O region
`define CSD_OFS_STACK_POINTER_LOW 6'h3d
`define CSD_OFS_STACK_POINTER_HIGH 6'h3e
`define CSD_OFS_PROCESSOR_STATUS 6'h3f
`define CSD_BIT_IO_LAST 6'h1f

// ==========================================================================
// Processor status fields and reset value
`define CSD_ST_I 7
`define CSD_ST_T 6
`define CSD_ST_H 5
`define CSD_ST_S 4
`define CSD_ST_V 3
`define CSD_ST_N 2
`define CSD_ST_Z 1
`define CSD_ST_C 0
`define CSD_STATUS_RESET 8'h00

// Stack moves in bytes
`define CSD_SP_STEP_DATA 1
`define CSD_SP_STEP_ADDR 2

`endif

// ==== csd_pkg.sv ====
// Types and shared decoding of the core status and data map
`include "csd_map.svh"

package csd_pkg;

    // ======================================================================
    // Access kinds requested by the execution logic
    typedef enum logic [2:0] {
        CSD_K_DIRECT,
        CSD_K_INDIRECT,
        CSD_K_PREDEC,
        CSD_K_POSTINC,
        CSD_K_IOPORT,
        CSD_K_BITSET,
        CSD_K_BITCLR,
        CSD_K_BITTEST
    } csd_kind_t;

    // Regions of the data space
    typedef enum logic [2:0] {
        CSD_R_IO,
        CSD_R_CORE,
        CSD_R_SRAM,
        CSD_R_LOCK,
        CSD_R_FLASH,
        CSD_R_NONE
    } csd_region_t;

    // Access sequencer states
    typedef enum logic [0:0] {
        CSD_S_IDLE,
        CSD_S_WAIT
    } csd_acc_st_t;

    // Region of a data address; core registers sit at the top of I/O
    function automatic csd_region_t csd_region(input logic [15:0] a);
        if (a <= `CSD_IO_LAST) begin
            if (a[5:0] >= `CSD_OFS_STACK_POINTER_LOW) begin
                return CSD_R_CORE;
            end
            return CSD_R_IO;
        end
        if (a <= `CSD_TOP_OF_SRAM) begin
            return CSD_R_SRAM;
        end
        if (a == `CSD_LOCK_ADDR) begin
            return CSD_R_LOCK;
        end
        if (a >= `CSD_FLASH_BASE && a <= `CSD_FLASH_LAST) begin
            return CSD_R_FLASH;
        end
        return CSD_R_NONE;
    endfunction

endpackage

// ==== csd_addr_gen.sv ====
// Effective address and pointer update for each data access kind
`timescale 1ns/1ps
`default_nettype none
`include "csd_map.svh"

module csd_addr_gen #(
    parameter logic [5:0] USART_LO = 6'h1c,
    parameter logic [5:0] USART_HI = 6'h1f
) (
    input wire csd_pkg::csd_kind_t kind_in,
    input wire logic [15:0] addr_in,
    input wire logic [15:0] ptr_in,
    output logic [15:0] eff_out,
    output logic [15:0] ptr_new_out,
    output logic ptr_upd_out,
    output logic legal_out
);
    import csd_pkg::*;

    // ======================================================================
    // Address formation
    // Pure decode; the caller registers everything it passes on
    always_comb begin
        eff_out = addr_in;
        ptr_new_out = ptr_in;
        ptr_upd_out = 1'b0;
        legal_out = 1'b1;
        case (kind_in)
            CSD_K_DIRECT: begin
                eff_out = `CSD_DIRECT_BASE + {9'h000, addr_in[6:0]};
                legal_out = (addr_in[15:7] == 9'h000);
            end
            CSD_K_INDIRECT: begin
                eff_out = ptr_in;
            end
            CSD_K_PREDEC: begin
                eff_out = ptr_in - 16'h0001;
                ptr_new_out = ptr_in - 16'h0001;
                ptr_upd_out = 1'b1;
            end
            CSD_K_POSTINC: begin
                eff_out = ptr_in;
                ptr_new_out = ptr_in + 16'h0001;
                ptr_upd_out = 1'b1;
            end
            CSD_K_IOPORT: begin
                eff_out = {10'h000, addr_in[5:0]};
                legal_out = (addr_in[15:6] == 10'h000);
            end
            CSD_K_BITSET, CSD_K_BITCLR, CSD_K_BITTEST: begin
                // Serial port registers refuse single-bit access
                eff_out = {10'h000, addr_in[5:0]};
                legal_out = (addr_in[15:5] == 11'h000) &&
                    !(addr_in[5:0] >= USART_LO && addr_in[5:0] <= USART_HI);
            end
            default: begin
                legal_out = 1'b0;
            end
        endcase
    end

endmodule

`default_nettype wire

// ==== csd_core_regs.sv ====
// Core stack pointer, processor status and data space access sequencer
//
// Operation
// - Stack pointer is high byte at 0x3E over low byte.
// - Reset loads stack pointer with top of SRAM; low byte at 0x3D.
// - No interrupt taken while global enable, status bit 7, is clear.
// - Taking an interrupt clears global enable; return-from-interrupt sets it.
// - Set and clear interrupt instructions set and clear global enable.
// - Status bit 6 holds the bit copied by bit store and load.
// - Sign flag at bit 4 always equals negative XOR overflow.
// - ALU results update zero, negative and carry flags.
// - Half carry and two's complement overflow are recorded in their flags.
// - Flash is 512 words of 16 bits, 9-bit counter from 0x000.
// - Program memory appears in data space from byte address 0x4000.
// - First 64 data addresses are I/O, next 32 are SRAM.
// - Lock bits and flash read in data space; writes are ignored. Here such writes change nothing but raise a fault.
// - Direct, indirect, pre-decrement and post-increment modes; R26 to R31 are pointers.
// - Port instructions reach all I/O; direct reaches 0x0040 to 0x00BF.
// - Pre-decrement and post-increment update the pointer; indirect reaches everything.
// - Each SRAM access completes in two clock cycles.
// - Single-bit instructions work on I/O 0x00 to 0x1F except serial port.
// - Single-bit set and clear change only the addressed bit.
// - Some flags clear when software writes a one to them.
// - Call or interrupt entry pushes return address, stack pointer minus 2.
// - After clear-interrupt no interrupt is taken, not even a simultaneous one.
`timescale 1ns/1ps
`default_nettype none
`include "csd_map.svh"

module csd_core_regs #(
    parameter int SRAM_BYTES = `CSD_SRAM_BYTES,
    parameter int SP_W = 7,
    parameter logic [5:0] USART_LO = 6'h1c,
    parameter logic [5:0] USART_HI = 6'h1f
) (
    input wire logic clock_in,
    input wire logic rst_in,
    // Data access request from the load/store datapath
    input wire logic acc_req_in,
    input wire csd_pkg::csd_kind_t acc_kind_in,
    input wire logic acc_we_in,
    input wire logic [15:0] acc_addr_in,
    input wire logic [2:0] acc_bit_in,
    input wire logic [7:0] acc_wdata_in,
    input wire logic [1:0] acc_ptr_sel_in,
    input wire logic [15:0] acc_ptr_in,
    output logic acc_busy_out,
    output logic acc_ack_out,
    output logic [7:0] acc_rdata_out,
    output logic acc_skip_out,
    output logic acc_fault_out,
    output logic ptr_wb_en_out,
    output logic [1:0] ptr_wb_sel_out,
    output logic [15:0] ptr_wb_out,
    // Peripheral I/O bus
    output logic io_we_out,
    output logic io_re_out,
    output logic [5:0] io_addr_out,
    output logic [7:0] io_wdata_out,
    output logic [7:0] io_wmask_out,
    input wire logic [7:0] io_rdata_in,
    // Program flash and lock bits
    output logic [`CSD_PC_WIDTH-1:0] flash_addr_out,
    input wire logic [15:0] flash_rdata_in,
    input wire logic [7:0] lock_bits_in,
    // Status flag updates from the ALU
    input wire logic alu_upd_in,
    input wire logic [4:0] alu_mask_in,
    input wire logic [7:0] alu_res_in,
    input wire logic alu_c_in,
    input wire logic alu_h_in,
    input wire logic alu_v_in,
    input wire logic bst_in,
    input wire logic bst_val_in,
    // Interrupt and stack control
    input wire logic sei_in,
    input wire logic cli_in,
    input wire logic return_from_irq_instr_in,
    input wire logic irq_req_in,
    input wire logic sp_push_in,
    input wire logic sp_pop_in,
    input wire logic sp_call_in,
    input wire logic sp_ret_in,
    output logic irq_take_out,
    output logic [7:0] status_out,
    output logic [15:0] stack_pointer_out
);
    import csd_pkg::*;

    localparam int IDX_W = $clog2(SRAM_BYTES);
    localparam logic [SP_W-1:0] SP_RESET = SP_W'(`CSD_TOP_OF_SRAM);

    // ======================================================================
    // Elaboration checks
    // The map is fixed, so the SRAM size and pointer width must match it
    if (SRAM_BYTES != `CSD_SRAM_BYTES) begin : g_bad_sram
        $error("SRAM size does not match the data map");
    end
    if (SP_W < 7 || SP_W > 16) begin : g_bad_sp
        $error("Stack pointer width cannot address the SRAM");
    end

    // ======================================================================
    // State
    typedef struct packed {
        csd_acc_st_t st;
        logic busy;
        logic [7:0] status;
        logic [SP_W-1:0] sp;
        logic [SRAM_BYTES-1:0][7:0] sram;
        logic [15:0] addr;
        csd_kind_t kind;
        logic legal;
        logic we;
        logic [2:0] bitn;
        logic [7:0] wdata;
        logic [7:0] wmask;
        logic ack;
        logic [7:0] rdata;
        logic skip;
        logic fault;
        logic io_we;
        logic io_re;
        logic [5:0] io_addr;
        logic [7:0] io_wdata;
        logic [7:0] io_wmask;
        logic [`CSD_PC_WIDTH-1:0] flash_addr;
        logic irq_take;
        logic ptr_wb_en;
        logic [1:0] ptr_wb_sel;
        logic [15:0] ptr_wb;
    } csd_state_t;

    csd_state_t q;
    csd_state_t d;

    logic [15:0] ag_eff;
    logic [15:0] ag_ptr_new;
    logic ag_ptr_upd;
    logic ag_legal;

    // ======================================================================
    // Address generation
    csd_addr_gen #(
        .USART_LO(USART_LO),
        .USART_HI(USART_HI)
    ) u_addr_gen (
        .kind_in(acc_kind_in),
        .addr_in(acc_addr_in),
        .ptr_in(acc_ptr_in),
        .eff_out(ag_eff),
        .ptr_new_out(ag_ptr_new),
        .ptr_upd_out(ag_ptr_upd),
        .legal_out(ag_legal)
    );

    // ======================================================================
    // Next state
    // Order inside one cycle: data write, ALU flags, bit store, interrupt
    // enable, then stack moves; later steps win where they overlap
    always_comb begin
        csd_region_t rg;
        logic [15:0] sram_off;
        logic [IDX_W-1:0] idx;
        logic [15:0] sp_full;
        logic [7:0] cur;
        logic take;
        rg = CSD_R_NONE;
        sram_off = 16'h0000;
        idx = '0;
        sp_full = 16'h0000;
        cur = 8'h00;
        take = 1'b0;
        d = q;
        d.ack = 1'b0;
        d.skip = 1'b0;
        d.io_we = 1'b0;
        d.io_re = 1'b0;
        d.irq_take = 1'b0;
        d.ptr_wb_en = 1'b0;

        case (q.st)
            CSD_S_IDLE: begin
                if (acc_req_in) begin
                    // Latch the request; every access then spends one wait cycle
                    rg = csd_region(ag_eff);
                    d.st = CSD_S_WAIT;
                    d.busy = 1'b1;
                    d.addr = ag_eff;
                    d.kind = acc_kind_in;
                    d.legal = ag_legal;
                    d.bitn = acc_bit_in;
                    d.fault = 1'b0;
                    d.we = acc_we_in;
                    d.wdata = acc_wdata_in;
                    d.wmask = 8'hff;
                    if (acc_kind_in == CSD_K_BITSET || acc_kind_in == CSD_K_BITCLR) begin
                        // A lone-bit mask keeps write-one-to-clear neighbours intact
                        d.we = 1'b1;
                        d.wmask = 8'h01 << acc_bit_in;
                        d.wdata = (acc_kind_in == CSD_K_BITSET) ? d.wmask : 8'h00;
                    end else if (acc_kind_in == CSD_K_BITTEST) begin
                        d.we = 1'b0;
                    end
                    // Pointer write-back for the auto-modify modes
                    d.ptr_wb_en = ag_ptr_upd;
                    d.ptr_wb = ag_ptr_new;
                    d.ptr_wb_sel = acc_ptr_sel_in;
                    // Peripheral strobes go out only for legal peripheral accesses
                    if (rg == CSD_R_IO && ag_legal) begin
                        d.io_addr = ag_eff[5:0];
                        d.io_we = d.we;
                        d.io_re = !d.we;
                        d.io_wdata = d.wdata;
                        d.io_wmask = d.wmask;
                    end
                    if (rg == CSD_R_FLASH) begin
                        sram_off = ag_eff - `CSD_FLASH_BASE;
                        d.flash_addr = sram_off[`CSD_PC_WIDTH:1];
                    end
                end
            end
            CSD_S_WAIT: begin
                // Second cycle: complete the access and answer
                rg = csd_region(q.addr);
                d.st = CSD_S_IDLE;
                d.busy = 1'b0;
                d.ack = 1'b1;
                d.rdata = 8'h00;
                d.fault = !q.legal;
                sram_off = q.addr - `CSD_SRAM_BASE;
                idx = sram_off[IDX_W-1:0];
                if (q.legal) begin
                    case (rg)
                        CSD_R_IO: begin
                            d.rdata = q.we ? 8'h00 : io_rdata_in;
                        end
                        CSD_R_CORE: begin
                            // Stack pointer bits above SP_W read zero
                            sp_full = 16'(q.sp);
                            case (q.addr[5:0])
                                `CSD_OFS_STACK_POINTER_LOW: cur = sp_full[7:0];
                                `CSD_OFS_STACK_POINTER_HIGH: cur = sp_full[15:8];
                                default: cur = q.status;
                            endcase
                            d.rdata = q.we ? 8'h00 : cur;
                            if (q.we) begin
                                cur = (cur & ~q.wmask) | (q.wdata & q.wmask);
                                case (q.addr[5:0])
                                    `CSD_OFS_STACK_POINTER_LOW: begin
                                        sp_full[7:0] = cur;
                                        d.sp = sp_full[SP_W-1:0];
                                    end
                                    `CSD_OFS_STACK_POINTER_HIGH: begin
                                        sp_full[15:8] = cur;
                                        d.sp = sp_full[SP_W-1:0];
                                    end
                                    default: d.status = cur;
                                endcase
                            end
                        end
                        CSD_R_SRAM: begin
                            if (q.we) begin
                                d.sram[idx] = q.wdata;
                            end else begin
                                d.rdata = q.sram[idx];
                            end
                        end
                        CSD_R_LOCK: begin
                            d.rdata = q.we ? 8'h00 : lock_bits_in;
                            d.fault = q.we;
                        end
                        CSD_R_FLASH: begin
                            // Odd byte address selects the high byte of the word
                            cur = q.addr[0] ? flash_rdata_in[15:8] : flash_rdata_in[7:0];
                            d.rdata = q.we ? 8'h00 : cur;
                            d.fault = q.we;
                        end
                        default: begin
                            d.fault = 1'b1;
                        end
                    endcase
                end
                if (q.kind == CSD_K_BITTEST) begin
                    d.skip = q.legal && d.rdata[q.bitn];
                end
            end
            default: begin
                d.st = CSD_S_IDLE;
                d.busy = 1'b0;
            end
        endcase

        // ALU flag updates, one mask bit per flag: C, Z, N, V, H
        if (alu_upd_in) begin
            if (alu_mask_in[0]) d.status[`CSD_ST_C] = alu_c_in;
            if (alu_mask_in[1]) d.status[`CSD_ST_Z] = (alu_res_in == 8'h00);
            if (alu_mask_in[2]) d.status[`CSD_ST_N] = alu_res_in[7];
            if (alu_mask_in[3]) d.status[`CSD_ST_V] = alu_v_in;
            if (alu_mask_in[4]) d.status[`CSD_ST_H] = alu_h_in;
        end
        if (bst_in) d.status[`CSD_ST_T] = bst_val_in;

        // Interrupt gate looks at the enable as it stood and at a same-cycle clear
        take = irq_req_in && q.status[`CSD_ST_I] && !cli_in;
        if (take) begin
            d.irq_take = 1'b1;
            d.status[`CSD_ST_I] = 1'b0;
        end
        if (return_from_irq_instr_in) d.status[`CSD_ST_I] = 1'b1;
        if (sei_in) d.status[`CSD_ST_I] = 1'b1;
        if (cli_in) begin
            d.status[`CSD_ST_I] = 1'b0;
        end
        d.status[`CSD_ST_S] = d.status[`CSD_ST_N] ^ d.status[`CSD_ST_V];

        // Stack moves wrap within SP_W bits
        if (sp_push_in) d.sp = d.sp - SP_W'(`CSD_SP_STEP_DATA);
        if (sp_pop_in) d.sp = d.sp + SP_W'(`CSD_SP_STEP_DATA);
        if (sp_call_in || take) d.sp = d.sp - SP_W'(`CSD_SP_STEP_ADDR);
        if (sp_ret_in) d.sp = d.sp + SP_W'(`CSD_SP_STEP_ADDR);

        // Synchronous reset values
        if (rst_in) begin
            d = '0;
            d.st = CSD_S_IDLE;
            d.status = `CSD_STATUS_RESET;
            d.sp = SP_RESET;
            d.flash_addr = `CSD_PC_RESET;
        end
    end

    // ======================================================================
    // Registers
    always_ff @(posedge clock_in) begin
        q <= d;
    end

    // ======================================================================
    // Outputs, all straight from the state register
    assign acc_busy_out = q.busy;
    assign acc_ack_out = q.ack;
    assign acc_rdata_out = q.rdata;
    assign acc_skip_out = q.skip;
    assign acc_fault_out = q.fault;
    assign ptr_wb_en_out = q.ptr_wb_en;
    assign ptr_wb_sel_out = q.ptr_wb_sel;
    assign ptr_wb_out = q.ptr_wb;
    assign io_we_out = q.io_we;
    assign io_re_out = q.io_re;
    assign io_addr_out = q.io_addr;
    assign io_wdata_out = q.io_wdata;
    assign io_wmask_out = q.io_wmask;
    assign flash_addr_out = q.flash_addr;
    assign irq_take_out = q.irq_take;
    assign status_out = q.status;
    assign stack_pointer_out = 16'(q.sp);

endmodule

`default_nettype wire

// ==== csd_core_regs_asserts.sv ====
// Concurrent checks on the core status and data map ports
`timescale 1ns/1ps
`default_nettype none

module csd_core_regs_asserts (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic acc_req_in,
    input wire logic acc_busy_out,
    input wire logic acc_ack_out,
    input wire logic [7:0] status_out,
    input wire logic [15:0] stack_pointer_out,
    input wire logic irq_take_out,
    input wire logic sei_in,
    input wire logic cli_in,
    input wire logic return_from_irq_instr_in,
    input wire logic sp_call_in
);
    // ==================================================================
    // Access timing and core state
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // A taken access waits one cycle, then answers
    sequence s_two; acc_busy_out ##1 acc_ack_out; endsequence
    sequence s_off; (!status_out[7] && !irq_take_out) ##1 !irq_take_out; endsequence
    property p_lat; acc_req_in && !acc_busy_out |=> s_two; endproperty
    property p_rst; $fell(rst_in) |-> status_out == 8'h00 && stack_pointer_out == 16'h005f; endproperty
    property p_sign; status_out[4] == (status_out[2] ^ status_out[3]); endproperty
    property p_gate; !status_out[7] |=> !irq_take_out; endproperty
    // Entry must clear the enable and push two bytes in the same edge
    property p_take; irq_take_out && !$past(sei_in || return_from_irq_instr_in || sp_call_in)
        |-> !status_out[7] && stack_pointer_out == $past(stack_pointer_out) - 16'h0002; endproperty
    property p_cli; cli_in |=> s_off; endproperty
    property p_set; (sei_in || return_from_irq_instr_in) && !cli_in |=> status_out[7]; endproperty
    property p_spw; stack_pointer_out[15:7] == 9'h000; endproperty
    a_lat: assert property (p_lat) else $error("access latency wrong");
    a_rst: assert property (p_rst) else $error("reset values wrong");
    a_sign: assert property (p_sign) else $error("sign flag wrong");
    a_gate: assert property (p_gate) else $error("interrupt while disabled");
    a_take: assert property (p_take) else $error("interrupt entry wrong");
    a_cli: assert property (p_cli) else $error("interrupt after clear");
    a_set: assert property (p_set) else $error("enable not set");
    a_spw: assert property (p_spw) else $error("stack pointer upper bits");
endmodule

bind csd_core_regs csd_core_regs_asserts u_chk (.clock_in, .rst_in, .acc_req_in, .acc_busy_out,
    .acc_ack_out, .status_out, .stack_pointer_out, .irq_take_out, .sei_in, .cli_in, .return_from_irq_instr_in,
    .sp_call_in);
`default_nettype wire

// ==== csd_periph_model.sv ====
// Peripheral registers, flash and lock byte seen from the core map
`timescale 1ns/1ps
`default_nettype none

module csd_periph_model (
    input wire logic clock_in,
    input wire logic io_we_in,
    input wire logic io_re_in,
    input wire logic [5:0] io_addr_in,
    input wire logic [7:0] io_wdata_in,
    input wire logic [7:0] io_wmask_in,
    input wire logic [8:0] flash_addr_in,
    output logic [7:0] io_rdata_out,
    output logic [15:0] flash_rdata_out,
    output logic [7:0] lock_bits_out
);
    logic [7:0] regs_q [64] = '{default: 8'h00};
    logic re_q = 1'b0;
    logic tog_q = 1'b0;
    // Only masked bits change, so neighbouring clear-by-one flags survive
    always_ff @(posedge clock_in) begin
        re_q <= io_re_in;
        tog_q <= ~tog_q;
        if (io_we_in) begin
            regs_q[io_addr_in] <= (regs_q[io_addr_in] & ~io_wmask_in) | (io_wdata_in & io_wmask_in);
        end
    end
    // Outside a read the bus shows a changing pattern, never stale data
    assign io_rdata_out = (io_re_in || re_q) ? regs_q[io_addr_in] : {8{tog_q}};
    assign flash_rdata_out = {~flash_addr_in[7:0], flash_addr_in[7:0]};
    assign lock_bits_out = 8'h3c;
endmodule
`default_nettype wire

// ==== cpu_status_and_data_map_tb.sv ====
// Self-checking bench for the core status and data map
`timescale 1ns/1ps
`default_nettype none

module cpu_status_and_data_map_tb;
    import csd_pkg::*;
    logic clock_in = 0, rst_in = 1, req = 0, we = 0, upd = 0, c = 0, h = 0, v = 0, bs = 0;
    logic bv = 0, sei = 0, clear_irq_instr = 0, return_from_irq_instr = 0, irq = 0, call = 0, ack, skp, flt, pwe, iowe, iore, tk;
    csd_kind_t kind = CSD_K_DIRECT;
    logic [15:0] addr = 0, sp, pw, pwo, fd;
    logic [7:0] wd = 0, res = 0, st, rd, mk, iord, iowd, iowm, lk;
    logic [5:0] ioa;
    logic [1:0] psel;
    logic [8:0] fa;
    logic [2:0] bn = 0;
    int fail_count = 0, n_checks = 0;
    always #5 clock_in = ~clock_in;
    csd_core_regs dut (.clock_in(clock_in), .rst_in(rst_in), .acc_req_in(req), .acc_kind_in(kind),
        .acc_we_in(we), .acc_addr_in(addr), .acc_bit_in(bn), .acc_wdata_in(wd), .acc_ptr_in(addr),
        .acc_ptr_sel_in(2'h2), .acc_busy_out(), .acc_ack_out(ack), .acc_rdata_out(rd),
        .acc_skip_out(skp), .acc_fault_out(flt), .ptr_wb_en_out(pwe), .ptr_wb_sel_out(psel),
        .ptr_wb_out(pwo), .io_we_out(iowe), .io_re_out(iore), .io_addr_out(ioa),
        .io_wdata_out(iowd), .io_wmask_out(iowm), .io_rdata_in(iord), .flash_addr_out(fa),
        .flash_rdata_in(fd), .lock_bits_in(lk), .alu_upd_in(upd), .alu_mask_in(5'h1f),
        .alu_res_in(res), .alu_c_in(c), .alu_h_in(h), .alu_v_in(v), .bst_in(bs), .bst_val_in(bv),
        .sei_in(sei), .cli_in(clear_irq_instr), .return_from_irq_instr_in(return_from_irq_instr), .irq_req_in(irq), .sp_push_in(1'b0),
        .sp_pop_in(1'b0), .sp_call_in(call), .sp_ret_in(1'b0), .irq_take_out(tk),
        .status_out(st), .stack_pointer_out(sp));
    csd_periph_model pm (.clock_in(clock_in), .io_we_in(iowe), .io_re_in(iore), .io_addr_in(ioa),
        .io_wdata_in(iowd), .io_wmask_in(iowm), .flash_addr_in(fa), .io_rdata_out(iord),
        .flash_rdata_out(fd), .lock_bits_out(lk));
    // ==================================================================
    // Shared helpers
    // ==================================================================
    task chk(input logic [23:0] g, input logic [23:0] e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %0t got %h want %h", $time, g, e);
        end
    endtask
    // One cycle pulse launched on a falling edge
    task automatic pls(ref logic s);
        s = 1;
        @(negedge clock_in);
        s = 0;
    endtask
    // Request held up to the take edge; the answer must be there two edges on
    task acc(input csd_kind_t k, input logic w, input logic [15:0] a, input logic [10:0] d);
        kind = k;
        we = w;
        addr = a;
        {bn, wd} = d;
        req = 1;
        @(negedge clock_in);
        req = 0;
        pw = (pwe && psel == 2'h2) ? pwo : 16'hdead;
        mk = iowe ? iowm : 8'h00;
        @(negedge clock_in);
        chk(ack, 1);
    endtask
    task alu(input logic [7:0] r, input logic [2:0] chv);
        res = r;
        {c, h, v} = chv;
        pls(upd);
    endtask
    // ==================================================================
    // Scenarios
    // ==================================================================
    task t_sram;
        acc(CSD_K_INDIRECT, 1, 16'h0045, 11'h0a5);
        acc(CSD_K_POSTINC, 0, 16'h0045, 0);
        chk({rd, pw}, {8'ha5, 16'h0046});
        acc(CSD_K_DIRECT, 1, 16'h0006, 11'h03c);
        acc(CSD_K_PREDEC, 0, 16'h0047, 0);
        chk({rd, pw}, {8'h3c, 16'h0046});
        acc(CSD_K_DIRECT, 0, 16'h001f, 0);
        chk(flt, 0);
        acc(CSD_K_INDIRECT, 0, 16'h0060, 0);
        chk(flt, 1);
    endtask
    task t_flash;
        acc(CSD_K_INDIRECT, 0, 16'h4003, 0);
        chk(rd, 8'hfe);
        acc(CSD_K_INDIRECT, 0, 16'h43fe, 0);
        chk(rd, 8'hff);
        acc(CSD_K_INDIRECT, 0, 16'h3f00, 0);
        chk(rd, 8'h3c);
        acc(CSD_K_INDIRECT, 1, 16'h4000, 11'h055);
        chk(flt, 1);
    endtask
    task t_bits;
        acc(CSD_K_IOPORT, 1, 16'h0005, 11'h081);
        acc(CSD_K_BITSET, 0, 16'h0005, 11'h300);
        chk(mk, 8'h08);
        acc(CSD_K_BITCLR, 0, 16'h0005, 11'h000);
        chk(mk, 8'h01);
        acc(CSD_K_IOPORT, 0, 16'h0005, 0);
        chk(rd, 8'h88);
        acc(CSD_K_BITTEST, 0, 16'h0005, 11'h700);
        chk(skp, 1);
        acc(CSD_K_BITSET, 0, 16'h001c, 0);
        chk({flt, mk}, 9'h100);
    endtask
    task t_flags;
        alu(8'h80, 3'b110);
        chk(st, 8'h35);
        alu(8'h00, 3'b001);
        chk(st, 8'h1a);
        bv = 1;
        pls(bs);
        chk(st, 8'h5a);
        acc(CSD_K_IOPORT, 1, 16'h003f, 11'h010);
        chk(st, 8'h00);
    endtask
    task t_irq;
        irq = 1;
        repeat (3) @(negedge clock_in);
        chk(tk, 0);
        pls(sei);
        @(negedge clock_in);
        chk({st[7], tk, sp}, {2'b01, 16'h005d});
        irq = 0;
        pls(return_from_irq_instr);
        chk(st[7], 1);
        irq = 1;
        pls(clear_irq_instr);
        @(negedge clock_in);
        chk({st[7], tk}, 0);
        irq = 0;
    endtask
    task t_sp;
        acc(CSD_K_IOPORT, 1, 16'h003d, 11'h050);
        acc(CSD_K_IOPORT, 1, 16'h003e, 11'h000);
        chk(sp, 16'h0050);
        acc(CSD_K_IOPORT, 0, 16'h003d, 0);
        chk(rd, 8'h50);
        pls(call);
        chk(sp, 16'h004e);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // The whole sequence needs about 72 cycles; allow over twenty-five times that
    initial begin
        #20000;
        fail_count++;
        summarize;
    end
    initial begin
        repeat (20) @(negedge clock_in);
        rst_in = 0;
        chk({st, sp}, {8'h00, 16'h005f});
        t_sram;
        t_flash;
        t_bits;
        t_flags;
        t_irq;
        t_sp;
        summarize;
    end
endmodule
`default_nettype wire
